// [pcs_map.svh]
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

`define PCS_OFF_IDS 8'h00
`define PCS_OFF_CMD_STS 8'h04
`define PCS_OFF_CLASS 8'h08
`define PCS_OFF_HDR 8'h0c
`define PCS_OFF_UART_IO_BASE 8'h10
`define PCS_OFF_BAR1 8'h14
`define PCS_OFF_BAR2 8'h18
`define PCS_OFF_LOCAL_REGS_MEM_BASE 8'h1c
`define PCS_OFF_STATUS_REGS_MEM_BASE 8'h20
`define PCS_OFF_CIS_PTR 8'h28
`define PCS_OFF_SUBSYS 8'h2c
`define PCS_OFF_CAP_PTR 8'h34
`define PCS_OFF_INTR 8'h3c
`define PCS_OFF_PM_CAP 8'h40
`define PCS_OFF_POWER_CONTROL_STATUS 8'h44
`define PCS_CIS_BASE 8'h48
`define PCS_CIS_BASE_RELOC 8'h80

`define PCS_CIS_PTR_NORMAL 32'h00000048
`define PCS_CIS_PTR_RELOC 32'h00000080
`define PCS_CIS_PTR_NONE 32'h00000000

`define PCS_RST_CMD 16'h0000
`define PCS_CMD_WMASK 16'h0547
`define PCS_RST_STATUS 16'h0290
`define PCS_STS_W1C 16'hf900
`define PCS_STS_CAP_BIT 4
`define PCS_RST_CLASS 24'h070006
`define PCS_RST_HDR 8'h00
`define PCS_RST_BIST 8'h00
`define PCS_RST_BAR_IO 32'h00000001
`define PCS_RST_BAR_MEM 32'h00000000
`define PCS_UART_IO_BITS 3
`define PCS_UART_MEM_BITS 12
`define PCS_CAP_PTR 8'h40
`define PCS_PM_CAP_ID 8'h01
`define PCS_PM_NEXT 8'h00
`define PCS_RST_PMC 16'h6c01
`define PCS_RST_POWER_CONTROL_STATUS 16'h0000
`define PCS_POWER_CONTROL_STATUS_WMASK 16'h0103
`define PCS_RST_INT_PIN 8'h01
`define PCS_RST_INT_LINE 8'h00
`define PCS_RST_MODE 1'b1
`define PCS_RST_RELOC 1'b0
`define PCS_LCR_MODE_BIT 0
`define PCS_LCR_RELOC_BIT 1

`define PCS_EE_IDS 4'h0
`define PCS_EE_CLASS 4'h1
`define PCS_EE_SUBSYS 4'h2
`define PCS_EE_INT_PIN 4'h3
`define PCS_EE_PMC 4'h4
`define PCS_EE_STS_CAP 4'h5
`define PCS_EE_LCR 4'h6
`define PCS_EE_TUPLE 4'h8

`endif

// [pcs_pkg.sv]
package pcs_pkg;
  typedef struct packed {
    logic [31:0] q;
  } pcs_reg_s;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [15:0] sts_err;
  } pcs_cfg_s;
endpackage

// [pcs_be_reg.sv]
module pcs_be_reg #(
  parameter logic [31:0] RESET = 32'h00000000,
  parameter logic [31:0] WMASK = 32'hffffffff
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic wr_in,
  input wire logic [3:0] be_in,
  input wire logic [31:0] wdata_in,
  output logic [31:0] q_out
);
  pcs_pkg::pcs_reg_s r;
  pcs_pkg::pcs_reg_s next_r;
  logic [31:0] lane;

  assign lane = {{8{be_in[3]}}, {8{be_in[2]}}, {8{be_in[1]}}, {8{be_in[0]}}} & WMASK;

  always_comb begin
    next_r = r;
    if (wr_in) begin
      // Only enabled lanes and writable bits change
      next_r.q = (r.q & ~lane) | (wdata_in & lane);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r.q <= RESET;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign q_out = r.q;
endmodule

// [pcs_ee_field.sv]
module pcs_ee_field #(
  parameter int W = 32,
  parameter logic [W-1:0] RESET = '0,
  parameter logic [3:0] SEL = 4'h0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic ee_wr_in,
  input wire logic [3:0] ee_sel_in,
  input wire logic [W-1:0] ee_data_in,
  output logic [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] q;
  } pcs_field_s;

  pcs_field_s r;
  pcs_field_s next_r;

  // No bus write path exists: only the loader can replace the default
  always_comb begin
    next_r = r;
    if (ee_wr_in && (ee_sel_in == SEL)) begin
      next_r.q = ee_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r.q <= RESET;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  assign q_out = r.q;
endmodule

// [pcs_config_space.sv]
// Functional notes
// - One configuration header; one information structure in card-bus mode; single function.
// - All mandatory header fields, allocated and reserved ones included, hold defined values.
// - Writes to unimplemented locations are dropped; reads there return zero.
// - Tuple bytes readable only in card-bus mode; otherwise tuple locations read zero.
// - Info pointer is 0x48 or 0x80 by relocate bit in card-bus mode, else zero.
// - Relocate bit loads only from serial EEPROM, resets to 0 (dword 18).
// - Capability pointer 0x40; power capability id 0x01, list end, control word at 44h.
// - Five base registers 10h to 20h; I/O ones reset 1, memory ones zero.
// - Identity, class, subsystem, interrupt pin, power capability: bus read-only, EEPROM loadable.
// - Answer only type 0 cycles to function 0; select line also needed in alternative mode.
// - Writes change only bytes whose byte enables are asserted.
// - UART I/O base requests 8 bytes; UART memory base requests 4K bytes.
// - Relocate is bit 1 of local control register, reset 0, 0 means dword 18.
`include "pcs_map.svh"

module pcs_config_space #(
  parameter logic [15:0] VENDOR_ID = 16'h1e5c,
  parameter logic [15:0] DEVICE_ID = 16'h7a21,
  parameter logic [7:0] REVISION_ID = 8'h5a,
  parameter logic [15:0] SUBSYS_VENDOR_ID = 16'h1e5c,
  parameter logic [15:0] SUBSYS_ID = 16'habcd,
  parameter int UART_IO_BITS = `PCS_UART_IO_BITS,
  parameter int UART_MEM_BITS = `PCS_UART_MEM_BITS,
  parameter int LOCAL_IO_BITS = 5,
  parameter int LOCAL_MEM_BITS = 12,
  parameter int STATUS_MEM_BITS = 12,
  parameter int TUPLE_DWORDS = 2,
  parameter logic [255:0] TUPLE_INIT = 256'h0
) (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CE_IN,
  input wire logic CFG_REQ_IN,
  input wire logic CFG_WRITE_IN,
  input wire logic CFG_TYPE0_IN,
  input wire logic [2:0] CFG_FUNC_IN,
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic [3:0] CFG_BE_IN,
  input wire logic [31:0] CFG_WDATA_IN,
  input wire logic CONFIG_SELECT_LINE_IN,
  input wire logic [15:0] STATUS_ERR_SET_IN,
  input wire logic EE_WR_IN,
  input wire logic [3:0] EE_SEL_IN,
  input wire logic [31:0] EE_DATA_IN,
  output logic CFG_ACK_OUT,
  output logic [31:0] CFG_RDATA_OUT,
  output logic [15:0] COMMAND_OUT,
  output logic CARDBUS_MODE_OUT,
  output logic CIS_RELOCATE_OUT
);
  // The sizing bits of a base register are simply not writable, so the
  // read-back after all ones reveals the requested size.
  localparam logic [31:0] UART_IO_MASK = ~((32'h1 << UART_IO_BITS) - 32'h1);
  localparam logic [31:0] UART_MEM_MASK = ~((32'h1 << UART_MEM_BITS) - 32'h1);
  localparam logic [31:0] LOCAL_IO_MASK = ~((32'h1 << LOCAL_IO_BITS) - 32'h1);
  localparam logic [31:0] LOCAL_MEM_MASK = ~((32'h1 << LOCAL_MEM_BITS) - 32'h1);
  localparam logic [31:0] STATUS_MEM_MASK = ~((32'h1 << STATUS_MEM_BITS) - 32'h1);

  if (TUPLE_DWORDS < 1 || TUPLE_DWORDS > 8) begin : g_bad_tuples
    $error("TUPLE_DWORDS must lie in 1..8");
  end
  if (UART_IO_BITS < 2 || UART_IO_BITS > 8 || LOCAL_IO_BITS < 2 || LOCAL_IO_BITS > 8) begin : g_bad_io
    $error("I/O base size bits must lie in 2..8");
  end
  if (UART_MEM_BITS < 4 || LOCAL_MEM_BITS < 4 || STATUS_MEM_BITS < 4) begin : g_bad_mem_lo
    $error("Memory base size bits must be at least 4");
  end
  if (UART_MEM_BITS > 31 || LOCAL_MEM_BITS > 31 || STATUS_MEM_BITS > 31) begin : g_bad_mem_hi
    $error("Memory base size bits must be at most 31");
  end

  pcs_pkg::pcs_cfg_s r;
  pcs_pkg::pcs_cfg_s next_r;

  logic take;
  logic wr_any;
  logic [7:0] dw_addr;
  logic [31:0] ids_q;
  logic [23:0] class_q;
  logic [31:0] subsys_q;
  logic [7:0] int_pin_q;
  logic [15:0] pmc_q;
  logic sts_cap_q;
  logic [1:0] lcr_q;
  logic [31:0] uart_io_base_q;
  logic [31:0] bar1_q;
  logic [31:0] bar2_q;
  logic [31:0] local_regs_mem_base_q;
  logic [31:0] status_regs_mem_base_q;
  logic [31:0] cmd_q;
  logic [31:0] line_q;
  logic [31:0] power_control_status_q;
  logic [31:0] tuple_q [TUPLE_DWORDS];
  logic [7:0] cis_base;
  logic [7:0] cis_off;
  logic [15:0] status_rd;
  logic [15:0] sts_clr;

  // Selection by the select line only matters outside card-bus mode
  assign take = CFG_REQ_IN && CFG_TYPE0_IN && (CFG_FUNC_IN == 3'h0) &&
                (lcr_q[`PCS_LCR_MODE_BIT] || CONFIG_SELECT_LINE_IN);
  assign wr_any = take && CFG_WRITE_IN;
  assign dw_addr = {CFG_ADDR_IN[7:2], 2'b00};
  assign cis_base = lcr_q[`PCS_LCR_RELOC_BIT] ? `PCS_CIS_BASE_RELOC : `PCS_CIS_BASE;
  assign cis_off = 8'(dw_addr - cis_base);

  pcs_ee_field #(.W(32), .RESET({DEVICE_ID, VENDOR_ID}), .SEL(`PCS_EE_IDS)) u_ids (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .ee_wr_in(EE_WR_IN),
    .ee_sel_in(EE_SEL_IN),
    .ee_data_in(EE_DATA_IN),
    .q_out(ids_q)
  );
  pcs_ee_field #(.W(24), .RESET(`PCS_RST_CLASS), .SEL(`PCS_EE_CLASS)) u_class (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .ee_wr_in(EE_WR_IN),
    .ee_sel_in(EE_SEL_IN),
    .ee_data_in(EE_DATA_IN[23:0]),
    .q_out(class_q)
  );
  pcs_ee_field #(.W(32), .RESET({SUBSYS_ID, SUBSYS_VENDOR_ID}), .SEL(`PCS_EE_SUBSYS)) u_subsys (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .ee_wr_in(EE_WR_IN),
    .ee_sel_in(EE_SEL_IN),
    .ee_data_in(EE_DATA_IN),
    .q_out(subsys_q)
  );
  pcs_ee_field #(.W(8), .RESET(`PCS_RST_INT_PIN), .SEL(`PCS_EE_INT_PIN)) u_int_pin (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .ee_wr_in(EE_WR_IN),
    .ee_sel_in(EE_SEL_IN),
    .ee_data_in(EE_DATA_IN[7:0]),
    .q_out(int_pin_q)
  );
  pcs_ee_field #(.W(16), .RESET(`PCS_RST_PMC), .SEL(`PCS_EE_PMC)) u_pmc (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .ee_wr_in(EE_WR_IN),
    .ee_sel_in(EE_SEL_IN),
    .ee_data_in(EE_DATA_IN[15:0]),
    .q_out(pmc_q)
  );
  pcs_ee_field #(
    .W(1), .RESET(1'(`PCS_RST_STATUS >> `PCS_STS_CAP_BIT)), .SEL(`PCS_EE_STS_CAP)
  ) u_sts_cap (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .ee_wr_in(EE_WR_IN),
    .ee_sel_in(EE_SEL_IN),
    .ee_data_in(EE_DATA_IN[0]),
    .q_out(sts_cap_q)
  );
  // Mode and relocate never see a bus write
  pcs_ee_field #(.W(2), .RESET({`PCS_RST_RELOC, `PCS_RST_MODE}), .SEL(`PCS_EE_LCR)) u_lcr (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .ee_wr_in(EE_WR_IN),
    .ee_sel_in(EE_SEL_IN),
    .ee_data_in(EE_DATA_IN[1:0]),
    .q_out(lcr_q)
  );

  for (genvar i = 0; i < TUPLE_DWORDS; i++) begin : g_tuple
    pcs_ee_field #(.W(32), .RESET(TUPLE_INIT[32*i +: 32]), .SEL(4'(`PCS_EE_TUPLE + i))) u_t (
      .clk_in(REF_CLK_IN), .rst_n_in(RESETN_IN), .ce_in(CE_IN),
      .ee_wr_in(EE_WR_IN), .ee_sel_in(EE_SEL_IN), .ee_data_in(EE_DATA_IN),
      .q_out(tuple_q[i])
    );
  end

  pcs_be_reg #(.RESET(`PCS_RST_BAR_IO), .WMASK(UART_IO_MASK)) u_uart_io_base (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_UART_IO_BASE)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(uart_io_base_q)
  );
  pcs_be_reg #(.RESET(`PCS_RST_BAR_MEM), .WMASK(UART_MEM_MASK)) u_bar1 (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_BAR1)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(bar1_q)
  );
  pcs_be_reg #(.RESET(`PCS_RST_BAR_IO), .WMASK(LOCAL_IO_MASK)) u_bar2 (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_BAR2)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(bar2_q)
  );
  pcs_be_reg #(.RESET(`PCS_RST_BAR_MEM), .WMASK(LOCAL_MEM_MASK)) u_local_regs_mem_base (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_LOCAL_REGS_MEM_BASE)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(local_regs_mem_base_q)
  );
  pcs_be_reg #(.RESET(`PCS_RST_BAR_MEM), .WMASK(STATUS_MEM_MASK)) u_status_regs_mem_base (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_STATUS_REGS_MEM_BASE)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(status_regs_mem_base_q)
  );
  pcs_be_reg #(.RESET({16'h0000, `PCS_RST_CMD}), .WMASK({16'h0000, `PCS_CMD_WMASK})) u_cmd (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_CMD_STS)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(cmd_q)
  );
  pcs_be_reg #(.RESET({24'h000000, `PCS_RST_INT_LINE}), .WMASK(32'h000000ff)) u_line (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_INTR)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(line_q)
  );
  pcs_be_reg #(.RESET({16'h0000, `PCS_RST_POWER_CONTROL_STATUS}), .WMASK({16'h0000, `PCS_POWER_CONTROL_STATUS_WMASK})) u_power_control_status (
    .clk_in(REF_CLK_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_in(wr_any && (dw_addr == `PCS_OFF_POWER_CONTROL_STATUS)),
    .be_in(CFG_BE_IN),
    .wdata_in(CFG_WDATA_IN),
    .q_out(power_control_status_q)
  );

  // Status: fixed bits from the reset pattern, error bits write-one-to-clear
  assign status_rd = (`PCS_RST_STATUS & ~`PCS_STS_W1C & ~(16'h1 << `PCS_STS_CAP_BIT)) |
                     (16'(sts_cap_q) << `PCS_STS_CAP_BIT) | r.sts_err;
  assign sts_clr = (wr_any && (dw_addr == `PCS_OFF_CMD_STS)) ?
                   (CFG_WDATA_IN[31:16] & {{8{CFG_BE_IN[3]}}, {8{CFG_BE_IN[2]}}}) : 16'h0000;

  always_comb begin
    next_r = r;
    next_r.ack = take;
    // A fresh error in the clearing cycle survives the clear
    next_r.sts_err = ((r.sts_err & ~sts_clr) | STATUS_ERR_SET_IN) & `PCS_STS_W1C;
    next_r.rdata = 32'h00000000;
    if (take && !CFG_WRITE_IN) begin
      case (dw_addr)
        `PCS_OFF_IDS: next_r.rdata = ids_q;
        `PCS_OFF_CMD_STS: next_r.rdata = {status_rd, cmd_q[15:0]};
        `PCS_OFF_CLASS: next_r.rdata = {class_q, REVISION_ID};
        `PCS_OFF_HDR: next_r.rdata = {`PCS_RST_BIST, `PCS_RST_HDR, 16'h0000};
        `PCS_OFF_UART_IO_BASE: next_r.rdata = uart_io_base_q;
        `PCS_OFF_BAR1: next_r.rdata = bar1_q;
        `PCS_OFF_BAR2: next_r.rdata = bar2_q;
        `PCS_OFF_LOCAL_REGS_MEM_BASE: next_r.rdata = local_regs_mem_base_q;
        `PCS_OFF_STATUS_REGS_MEM_BASE: next_r.rdata = status_regs_mem_base_q;
        `PCS_OFF_CIS_PTR: begin
          if (!lcr_q[`PCS_LCR_MODE_BIT]) begin
            next_r.rdata = `PCS_CIS_PTR_NONE;
          end else if (lcr_q[`PCS_LCR_RELOC_BIT]) begin
            next_r.rdata = `PCS_CIS_PTR_RELOC;
          end else begin
            next_r.rdata = `PCS_CIS_PTR_NORMAL;
          end
        end
        `PCS_OFF_SUBSYS: next_r.rdata = subsys_q;
        `PCS_OFF_CAP_PTR: next_r.rdata = {24'h000000, `PCS_CAP_PTR};
        `PCS_OFF_INTR: next_r.rdata = {16'h0000, int_pin_q, line_q[7:0]};
        `PCS_OFF_PM_CAP: next_r.rdata = {pmc_q, `PCS_PM_NEXT, `PCS_PM_CAP_ID};
        `PCS_OFF_POWER_CONTROL_STATUS: next_r.rdata = {16'h0000, power_control_status_q[15:0]};
        default: begin
          // Tuple window moves with relocate and vanishes in alternative mode
          for (int i = 0; i < TUPLE_DWORDS; i++) begin
            if (lcr_q[`PCS_LCR_MODE_BIT] && (dw_addr >= cis_base) &&
                (cis_off[7:2] == 6'(i))) begin
              next_r.rdata = tuple_q[i];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      r <= '0;
    end else if (CE_IN) begin
      r <= next_r;
    end
  end

  assign CFG_ACK_OUT = r.ack;
  assign CFG_RDATA_OUT = r.rdata;
  assign COMMAND_OUT = cmd_q[15:0];
  assign CARDBUS_MODE_OUT = lcr_q[`PCS_LCR_MODE_BIT];
  assign CIS_RELOCATE_OUT = lcr_q[`PCS_LCR_RELOC_BIT];
endmodule

// [pcs_config_space_props.sv]
`include "pcs_map.svh"

module pcs_cs_props (
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic CE_IN,
  input wire logic CFG_REQ_IN,
  input wire logic CFG_WRITE_IN,
  input wire logic CFG_TYPE0_IN,
  input wire logic [2:0] CFG_FUNC_IN,
  input wire logic [7:0] CFG_ADDR_IN,
  input wire logic CONFIG_SELECT_LINE_IN,
  input wire logic EE_WR_IN,
  input wire logic CFG_ACK_OUT,
  input wire logic [31:0] CFG_RDATA_OUT,
  input wire logic [15:0] COMMAND_OUT,
  input wire logic CARDBUS_MODE_OUT,
  input wire logic CIS_RELOCATE_OUT
);
  logic tk;
  logic rd;
  logic [5:0] dw;
  logic [31:0] cis;
  assign tk = CE_IN && CFG_REQ_IN && CFG_TYPE0_IN && CFG_FUNC_IN == 3'h0
    && (CARDBUS_MODE_OUT || CONFIG_SELECT_LINE_IN);
  assign rd = tk && !CFG_WRITE_IN;
  assign dw = CFG_ADDR_IN[7:2];
  assign cis = !CARDBUS_MODE_OUT ? `PCS_CIS_PTR_NONE
    : CIS_RELOCATE_OUT ? `PCS_CIS_PTR_RELOC : `PCS_CIS_PTR_NORMAL;
  default clocking @(posedge REF_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  ack_claim_a: assert property (tk |=> CFG_ACK_OUT)
    else $error("claimed access not acknowledged");
  ack_refuse_a: assert property (CE_IN && !tk |=> !CFG_ACK_OUT)
    else $error("acknowledge without claimed access");
  rdata_idle_a: assert property (CE_IN && !rd |=> CFG_RDATA_OUT == 32'h0)
    else $error("read data not zero outside a read");
  unimpl_zero_a: assert property (rd && dw inside {6'h09, 6'h0c, 6'h0e, 6'h3f}
    |=> CFG_RDATA_OUT == 32'h0) else $error("unimplemented location not zero");
  cap_ptr_a: assert property (rd && dw == 6'h0d |=> CFG_RDATA_OUT[7:0] == `PCS_CAP_PTR)
    else $error("capability pointer wrong");
  pm_header_a: assert property (rd && dw == 6'h10
    |=> CFG_RDATA_OUT[15:0] == {`PCS_PM_NEXT, `PCS_PM_CAP_ID}) else $error("pm header wrong");
  cis_ptr_a: assert property (rd && dw == 6'h0a |=> CFG_RDATA_OUT == $past(cis))
    else $error("info pointer wrong");
  tuple_off_a: assert property (rd && !CARDBUS_MODE_OUT && CFG_ADDR_IN[7:3] == 5'h09
    |=> CFG_RDATA_OUT == 32'h0) else $error("tuple visible in alternative mode");
  bar_io_size_a: assert property (rd && dw == 6'h04 |=> CFG_RDATA_OUT[2:0] == 3'b001)
    else $error("uart io base low bits wrong");
  reloc_hold_a: assert property (!EE_WR_IN |=> $stable(CIS_RELOCATE_OUT))
    else $error("relocate changed without loader");
  cmd_hold_a: assert property (!(tk && CFG_WRITE_IN && dw == 6'h01)
    |=> $stable(COMMAND_OUT)) else $error("command changed without write");
  cover property (rd && dw == 6'h0a && CIS_RELOCATE_OUT);
  cover property (tk && CFG_WRITE_IN && dw == 6'h05);
  cover property (CFG_REQ_IN && !CARDBUS_MODE_OUT && !CONFIG_SELECT_LINE_IN);
endmodule

bind pcs_config_space pcs_cs_props chk_u (.REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN),
  .CE_IN(CE_IN), .CFG_REQ_IN(CFG_REQ_IN), .CFG_WRITE_IN(CFG_WRITE_IN),
  .CFG_TYPE0_IN(CFG_TYPE0_IN), .CFG_FUNC_IN(CFG_FUNC_IN), .CFG_ADDR_IN(CFG_ADDR_IN),
  .CONFIG_SELECT_LINE_IN(CONFIG_SELECT_LINE_IN), .EE_WR_IN(EE_WR_IN),
  .CFG_ACK_OUT(CFG_ACK_OUT), .CFG_RDATA_OUT(CFG_RDATA_OUT), .COMMAND_OUT(COMMAND_OUT),
  .CARDBUS_MODE_OUT(CARDBUS_MODE_OUT), .CIS_RELOCATE_OUT(CIS_RELOCATE_OUT));

// [pcs_host_model.sv]
module pcs_host_model (
  input wire logic clk_in,
  output logic req_out,
  output logic write_out,
  output logic type0_out,
  output logic [2:0] func_out,
  output logic [7:0] addr_out,
  output logic [3:0] be_out,
  output logic [31:0] wdata_out,
  output logic sel_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_out = 1'b0;
    write_out = 1'b0;
    type0_out = 1'b0;
    func_out = 3'h7;
    addr_out = 8'h0;
    be_out = 4'h0;
    wdata_out = 32'h0;
    sel_out = 1'b0;
  end
  // One dword per access, request stands for one edge only
  task automatic cfg(input logic w, input logic t0, input logic [2:0] fn, input logic s,
      input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk_in);
    req_out = 1'b1;
    write_out = w;
    type0_out = t0;
    func_out = fn;
    sel_out = s;
    addr_out = a;
    be_out = b;
    wdata_out = d;
    @(negedge clk_in);
    req_out = 1'b0;
    // Address, byte enables, data and select flip so a stale value can never look valid
    addr_out = ~a;
    be_out = ~b;
    wdata_out = ~d;
    sel_out = ~s;
  endtask
endmodule

// [pcs_config_space_tb.sv]
module pcs_config_space_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic req, wr, t0, sel, ack, cbm, rel;
  logic [2:0] fn;
  logic [7:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, w;
  logic [15:0] st_set = 16'h0;
  logic [15:0] cmd;
  logic ee_wr = 1'b0;
  logic [3:0] ee_sel = 4'h0;
  logic [31:0] ee_data = 32'h0;
  logic [15:0] seed = 16'h4ff3;
  logic [31:0] exp_q[$];
  logic [31:0] rv [19] = '{32'h7a211e5c, 32'h02900000, 32'h0700065a, 0, 1, 0, 1, 0, 0, 0,
    32'h48, 32'habcd1e5c, 0, 32'h40, 0, 32'h100, 32'h6c010001, 0, 0};
  logic [31:0] bm [5] = '{32'hfffffff8, 32'hfffff000, 32'hffffffe0, 32'hfffff000, 32'hfffff000};
  int err_total = 0;
  int comparisons = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  pcs_host_model host_u (.clk_in(clk), .req_out(req), .write_out(wr), .type0_out(t0),
    .func_out(fn), .addr_out(addr), .be_out(be), .wdata_out(wdata), .sel_out(sel));
  pcs_config_space dut_u (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce), .CFG_REQ_IN(req),
    .CFG_WRITE_IN(wr), .CFG_TYPE0_IN(t0), .CFG_FUNC_IN(fn), .CFG_ADDR_IN(addr),
    .CFG_BE_IN(be), .CFG_WDATA_IN(wdata), .CONFIG_SELECT_LINE_IN(sel),
    .STATUS_ERR_SET_IN(st_set), .EE_WR_IN(ee_wr), .EE_SEL_IN(ee_sel), .EE_DATA_IN(ee_data),
    .CFG_ACK_OUT(ack), .CFG_RDATA_OUT(rdata), .COMMAND_OUT(cmd), .CARDBUS_MODE_OUT(cbm),
    .CIS_RELOCATE_OUT(rel));
  function logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    rnd = {seed, ~seed[7:0], seed[15:8]};
  endfunction
  task automatic end_sim();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
      input logic [31:0] d, input logic [31:0] e);
    exp_q.push_back(w ? 32'h0 : e);
    host_u.cfg(w, 1'b1, 3'h0, 1'b1, a, b, d);
  endtask
  task automatic wr_rd(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d,
      input logic [31:0] e);
    acc(1'b1, a, b, d, 32'h0);
    acc(1'b0, a, 4'hf, 32'h0, e);
  endtask
  // Write mode hits only the read-only and unimplemented places
  task automatic tab(input logic w);
    for (int i = 0; i < 19; i++) begin
      if (!w)
        acc(1'b0, (i == 18) ? 8'hfc : 8'(4 * i), 4'hf, 32'h0, rv[i]);
      else if (!(i inside {1, 4, 5, 6, 7, 8, 15, 17}))
        acc(1'b1, (i == 18) ? 8'hfc : 8'(4 * i), 4'hf, 32'hffffffff, 32'h0);
    end
  endtask
  task automatic ee(input logic [3:0] s, input logic [31:0] d);
    @(negedge clk);
    ee_wr = 1'b1;
    ee_sel = s;
    ee_data = d;
    @(negedge clk);
    ee_wr = 1'b0;
    ee_data = ~d;
  endtask
  always @(negedge clk) begin
    if (ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("Error at %0t: unexpected acknowledge", $time);
      end else begin
        chk(rdata, exp_q.pop_front());
      end
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      $display("Error at %0t: timeout", $time);
      end_sim();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk({30'h0, cbm, rel}, 32'h2);
    tab(1'b0);
    $display("test reset values done");
    tab(1'b1);
    tab(1'b0);
    $display("test read-only writes done");
    for (int i = 0; i < 5; i++) begin
      w = rnd();
      wr_rd(8'(16 + 4 * i), 4'hf, w, w & bm[i] | {31'h0, i == 0 || i == 2});
    end
    wr_rd(8'h04, 4'hf, 32'h0000ffff, 32'h02900547);
    chk({16'h0, cmd}, 32'h547);
    wr_rd(8'h3c, 4'hf, 32'hffffffff, 32'h1ff);
    wr_rd(8'h44, 4'hf, 32'hffffffff, 32'h103);
    wr_rd(8'h14, 4'hf, 32'h0, 32'h0);
    wr_rd(8'h14, 4'h4, 32'hffffffff, 32'h00ff0000);
    $display("test writable fields done");
    wr_rd(8'h10, 4'hf, 32'h0, 32'h1);
    host_u.cfg(1'b1, 1'b0, 3'h0, 1'b1, 8'h10, 4'hf, 32'hffffffff);
    host_u.cfg(1'b1, 1'b1, 3'h1, 1'b1, 8'h10, 4'hf, 32'hffffffff);
    acc(1'b0, 8'h10, 4'hf, 32'h0, 32'h1);
    $display("test refused cycles done");
    w = rnd();
    ee(4'h8, w);
    acc(1'b0, 8'h48, 4'hf, 32'h0, w);
    ee(4'h6, 32'h3);
    chk({30'h0, cbm, rel}, 32'h3);
    acc(1'b0, 8'h28, 4'hf, 32'h0, 32'h80);
    acc(1'b0, 8'h80, 4'hf, 32'h0, w);
    ee(4'h6, 32'h0);
    acc(1'b0, 8'h28, 4'hf, 32'h0, 32'h0);
    acc(1'b0, 8'h48, 4'hf, 32'h0, 32'h0);
    host_u.cfg(1'b0, 1'b1, 3'h0, 1'b0, 8'h00, 4'hf, 32'h0);
    ee(4'h6, 32'h1);
    ee(4'h0, w);
    acc(1'b0, 8'h00, 4'hf, 32'h0, w);
    acc(1'b0, 8'h28, 4'hf, 32'h0, 32'h48);
    $display("test loader and modes done");
    @(negedge clk) st_set = 16'hf900;
    @(negedge clk) st_set = 16'h0;
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'hfb900547);
    wr_rd(8'h04, 4'hc, 32'hffff0000, 32'h02900547);
    // Error held across its own clear must survive it
    st_set = 16'h8000;
    acc(1'b1, 8'h04, 4'hc, 32'hffff0000, 32'h0);
    st_set = 16'h0000;
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h82900547);
    wr_rd(8'h04, 4'hc, 32'h80000000, 32'h02900547);
    $display("test status bits done");
    // Frozen block must ignore a claimed write
    @(negedge clk) ce = 1'b0;
    host_u.cfg(1'b1, 1'b1, 3'h0, 1'b1, 8'h04, 4'hf, 32'h0);
    @(negedge clk) ce = 1'b1;
    acc(1'b0, 8'h04, 4'hf, 32'h0, 32'h02900547);
    $display("test clock enable done");
    @(negedge clk) rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk({30'h0, cbm, rel}, 32'h2);
    tab(1'b0);
    $display("test mid-run reset done");
    repeat (3) @(negedge clk);
    chk(exp_q.size(), 32'h0);
    end_sim();
  end
endmodule
